// [bench/qcr_regs_tb.sv]
// Purpose: Self-checking bench of the channel configuration register bank
// Assumes: APB answer one cycle after setup; config outputs one cycle late
// Notes:   Expected values come from the register layout, not the design
`default_nettype none
module testbench
  import qcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_in;
  logic                sys_rst_in;
  logic                psel_in;
  logic                penable_in;
  logic                pwrite_in;
  logic [15:0]         paddr_in;
  logic [31:0]         pwdata_in;
  logic                glb_in;
  logic                pready;
  logic [31:0]         prdata;
  logic                pslverr;
  logic [127:0][26:0]  k_word;
  logic [127:0][26:0]  l_word;
  logic [127:0]        f_pulse;
  logic [127:0]        r_pulse;
  logic [127:0]        prbs_en;
  logic [127:0][5:0]   seed;
  logic [127:0][1:0]   rolloff;
  logic [127:0]        constellation_offset_enable;
  logic [127:0][2:0]   csel;
  logic [127:0]        bypass;
  logic [127:0]        half;
  logic [127:0][3:0]   coarse;
  int                  fail_count;
  int                  checked;
  int                  cycles;
  int                  f_cnt;
  int                  r_cnt;
  logic [31:0]         rd;
  logic                err;

  qcr_regs i_dut (
    .clk_in                          (clk_in),
    .sys_rst_in                      (sys_rst_in),
    .psel_in                         (psel_in),
    .penable_in                      (penable_in),
    .pwrite_in                       (pwrite_in),
    .paddr_in                        (paddr_in),
    .pwdata_in                       (pwdata_in),
    .global_ratio_load_in            (glb_in),
    .pready_out                      (pready),
    .prdata_out                      (prdata),
    .pslverr_out                     (pslverr),
    .resampler_k_word_out            (k_word),
    .resampler_l_word_out            (l_word),
    .freq_word_load_pulse_out        (f_pulse),
    .ratio_word_load_pulse_out       (r_pulse),
    .prbs_enable_out                 (prbs_en),
    .prbs_seed_low_out               (seed),
    .rolloff_sel_out                 (rolloff),
    .constellation_offset_enable_out (constellation_offset_enable),
    .constellation_sel_out           (csel),
    .mapper_bypass_out               (bypass),
    .half_symbol_delay_enable_out    (half),
    .coarse_symbol_delay_out         (coarse)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    f_cnt  <= f_cnt + $countones(f_pulse);
    r_cnt  <= r_cnt + $countones(r_pulse);
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [10:0] idx,
                     input logic [15:0] d);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= {3'h0, idx, 2'h0};
    pwdata_in  <= {16'hFFFF, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rchk(input logic [10:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(rd, {16'h0000, exp});
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_in);
  endtask

  initial begin
    psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0;
    paddr_in = 16'h0000; pwdata_in = 32'h0; glb_in = 1'b0;
    fail_count = 0; checked = 0; cycles = 0; f_cnt = 0; r_cnt = 0;
    sys_rst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rchk(11'h108, 16'h01C0);
    chk({29'h0, csel[0]}, {29'h0, QCR_C_BYPASS});
    chk({31'h0, bypass[0]}, 32'h1);
    rchk(11'h146, 16'h0000);
    rchk(11'h10A, 16'h0000);
    rchk(11'h10B, 16'h0000);
    // Block 2 local channel 3 is global channel 11, index 10
    apb(1'b1, 11'h146, 16'h5000);
    apb(1'b1, 11'h145, 16'h0003);
    apb(1'b1, 11'h157, 16'h1234);
    apb(1'b1, 11'h158, 16'hABCD);
    apb(1'b1, 11'h159, 16'h5678);
    rchk(11'h146, 16'h5000);
    rchk(11'h145, 16'h0003);
    rchk(11'h158, 16'hABCD);
    settle();
    chk({5'h0, k_word[10]}, 32'h0);
    apb(1'b1, 11'h156, 16'h41C0);
    settle();
    chk(r_cnt, 32'h1);
    chk({5'h0, k_word[10]}, {5'h0, 3'b110, 8'hAB, 16'h1234});
    chk({5'h0, l_word[10]}, {5'h0, 3'b101, 8'hCD, 16'h5678});
    rchk(11'h156, 16'h01C0);
    apb(1'b1, 11'h156, 16'h81C0);
    settle();
    chk(f_cnt, 32'h1);
    chk(r_cnt, 32'h1);
    rchk(11'h156, 16'h01C0);
    // Global load reaches only channels with the enable set
    apb(1'b1, 11'h156, 16'h21C0);
    apb(1'b1, 11'h157, 16'h0001);
    apb(1'b1, 11'h109, 16'h00FF);
    settle();
    chk({5'h0, k_word[10]}, {5'h0, 3'b110, 8'hAB, 16'h1234});
    @(posedge clk_in);
    glb_in <= 1'b1;
    @(posedge clk_in);
    glb_in <= 1'b0;
    settle();
    chk({5'h0, k_word[10]}, {5'h0, 3'b110, 8'hAB, 16'h0001});
    chk({5'h0, k_word[0]}, 32'h0);
    // Every constellation and roll-off code on channel 1
    for (int q = 0; q < 8; q++) begin
      apb(1'b1, 11'h108, 16'((q % 4) << 10 | q << 6 | 16'h001A));
      settle();
      chk({30'h0, rolloff[0]}, 32'(q % 4));
      chk({29'h0, csel[0]}, 32'(q));
      chk({31'h0, bypass[0]}, {31'h0, q == 7});
      chk({31'h0, constellation_offset_enable[0]}, 32'h0);
      chk({31'h0, half[0]}, 32'h1);
      chk({28'h0, coarse[0]}, 32'hA);
      chk({31'h0, prbs_en[0]}, 32'h0);
      chk({26'h0, seed[0]}, 32'h0);
    end
    apb(1'b1, 11'h108, 16'h13FF);
    settle();
    chk({31'h0, prbs_en[0]}, 32'h1);
    chk({31'h0, constellation_offset_enable[0]}, 32'h1);
    chk({26'h0, seed[0]}, 32'h3F);
    chk({31'h0, half[0]}, 32'h0);
    chk({28'h0, coarse[0]}, 32'h0);
    // Decode at the far ends of the map
    apb(1'b1, 11'h4FA, 16'hC33C);
    rchk(11'h4FA, 16'hC33C);
    apb(1'b1, 11'h4C6, 16'h9009);
    rchk(11'h4C6, 16'h9009);
    apb(1'b1, 11'h10C, 16'h1111);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 11'h10C, 16'h0000);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire

// [design/qcr_consts.svh]
// Purpose: Constants of the channel configuration register bank
// Assumes: Register indexes are word indexes; byte address is index * 4
// Notes:   Timing-free block, no counts
`ifndef QCR_CONSTS_SVH
`define QCR_CONSTS_SVH
`define QCR_NUM_BLK     16
`define QCR_NUM_CH      128
`define QCR_CH_PER_BLK  8
`define QCR_REG_BASE    11'h100
`define QCR_MSB2_IDX    11'h105
`define QCR_MSB3_IDX    11'h106
`define QCR_SYM_IDX     11'h108
`define QCR_KLO_IDX     11'h109
`define QCR_MID_IDX     11'h10A
`define QCR_LLO_IDX     11'h10B
`define QCR_BLK_STRIDE  11'h040
`define QCR_CH_STRIDE   11'h007
`define QCR_GRP_STRIDE  11'h008
`define QCR_DIV7_MUL    12'h025
`define QCR_B_LDF       15
`define QCR_B_LDR       14
`define QCR_B_GLB       13
`define QCR_B_PRBS      12
`define QCR_B_ALPHA     10
`define QCR_B_CONSTELLATION_OFFSET_ENABLE      9
`define QCR_B_QAM       6
`define QCR_B_HALF      4
`define QCR_B_D1        0
`define QCR_SYM_RST     14'h01C0
`define QCR_QAM_RST     3'h7
`define QCR_WORD_RST    16'h0000
`define QCR_UP_LSB      24
`define QCR_UP_PER_CH   6
`endif

// [design/qcr_pkg.sv]
// Purpose: Types of the channel configuration register bank
// Assumes: Shared by the register bank and its bench
// Notes:   Constants live in qcr_consts.svh
`default_nettype none
package qcr_pkg;
  typedef enum logic [2:0] {
    QCR_K_NONE, QCR_K_MSB2, QCR_K_MSB3, QCR_K_SYM,
    QCR_K_KLO, QCR_K_MID, QCR_K_LLO
  } qcr_kind_e;
  typedef enum logic [1:0] {
    QCR_RO_012 = 2'h0, QCR_RO_013 = 2'h1,
    QCR_RO_015 = 2'h2, QCR_RO_018 = 2'h3
  } qcr_rolloff_e;
  typedef enum logic [2:0] {
    QCR_C_TCM256 = 3'h0, QCR_C_TCM64 = 3'h1, QCR_C_DG16 = 3'h2,
    QCR_C_DG32 = 3'h3, QCR_C_DG64 = 3'h4, QCR_C_DG128 = 3'h5,
    QCR_C_DG256 = 3'h6, QCR_C_BYPASS = 3'h7
  } qcr_const_e;
  typedef logic [26:0] qcr_ratio_t;
endpackage
`default_nettype wire

// [design/qcr_regs.sv]
// Purpose: Per-channel symbol interface and resampler ratio registers
// Assumes: APB slave, no wait state, 16-bit registers in low data bits
// Notes:   Ratio words are staged and applied only on a load
`include "qcr_consts.svh"
`default_nettype none
// Contract
// - Thirty-two 16-bit ratio upper registers, two per block at 0x105 and 0x106, in 0x40 steps.
// - Channel registers at base plus ch*7 plus group*8, symbol base 0x108.
// - Local channel N of block b is global channel N plus (b-1)*8.
// - Both ratio words are plain unsigned integers without sign bit.
// - Upper register packs L then K three-bit tops per channel; with only 32 upper bits, tops past channel 6 L bit 25 read zero.
// - Middle register holds K bits 23:16 high and L bits 23:16 low.
// - K bits 15:0 at 0x109, L bits 15:0 at 0x10B.
// - Bit 15 one issues single frequency word load, then clears.
// - Bit 14 one issues single ratio word load, then clears.
// - Bit 13 lets the global load update this channel's ratio words.
// - Bit 12 selects the internal pseudo-random source for the channel.
// - Bits 11:10 choose roll-off 0.12, 0.13, 0.15 or 0.18.
// - Bit 9 enables the constellation offset bit.
// - Bits 8:6 select trellis or differential Gray constellation.
// - Code 111, the reset value, bypasses mapping with register offset.
// - Bit 4 inserts a half-symbol delay stage.
// - Bits 3:0 give the coarse symbol delay.
// - With pseudo-random on, low six bits become seed, not delay.
// - Channel 3 K bits 26:25 sit in bits 1:0 of 0x105.
module qcr_regs
  import qcr_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [15:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  input  wire logic                  global_ratio_load_in,
  output var  logic                  pready_out,
  output var  logic [31:0]           prdata_out,
  output var  logic                  pslverr_out,
  output var  logic [127:0][26:0]    resampler_k_word_out,
  output var  logic [127:0][26:0]    resampler_l_word_out,
  output var  logic [127:0]          freq_word_load_pulse_out,
  output var  logic [127:0]          ratio_word_load_pulse_out,
  output var  logic [127:0]          prbs_enable_out,
  output var  logic [127:0][5:0]     prbs_seed_low_out,
  output var  logic [127:0][1:0]     rolloff_sel_out,
  output var  logic [127:0]          constellation_offset_enable_out,
  output var  logic [127:0][2:0]     constellation_sel_out,
  output var  logic [127:0]          mapper_bypass_out,
  output var  logic [127:0]          half_symbol_delay_enable_out,
  output var  logic [127:0][3:0]     coarse_symbol_delay_out
);

  localparam logic [5:0] LOC_MSB2 = 6'(`QCR_MSB2_IDX - `QCR_REG_BASE);
  localparam logic [5:0] LOC_MSB3 = 6'(`QCR_MSB3_IDX - `QCR_REG_BASE);
  localparam logic [5:0] LOC_SYM  = 6'(`QCR_SYM_IDX - `QCR_REG_BASE);
  localparam logic [2:0] R_KLO    = 3'(`QCR_KLO_IDX - `QCR_SYM_IDX);
  localparam logic [2:0] R_MID    = 3'(`QCR_MID_IDX - `QCR_SYM_IDX);
  localparam logic [2:0] R_LLO    = 3'(`QCR_LLO_IDX - `QCR_SYM_IDX);

  logic [15:0]  msb2_r [`QCR_NUM_BLK];
  logic [15:0]  msb3_r [`QCR_NUM_BLK];
  logic [13:0]  sym_r  [`QCR_NUM_CH];
  logic [15:0]  klo_r  [`QCR_NUM_CH];
  logic [15:0]  mid_r  [`QCR_NUM_CH];
  logic [15:0]  llo_r  [`QCR_NUM_CH];

  logic [10:0]  idx;
  logic [10:0]  rel;
  logic [3:0]   blk;
  logic [5:0]   loc;
  logic [5:0]   m;
  logic [11:0]  prod;
  logic [2:0]   n;
  logic [2:0]   r;
  logic [6:0]   ch;
  qcr_kind_e    kind;
  logic [15:0]  rd_data;
  logic         setup;
  logic         wr_en;

  // Staged 27-bit ratio word of a channel
  function automatic qcr_ratio_t ratio_word(input int c, input logic is_k);
    logic [47:0] seq;
    logic [5:0]  pos;
    seq = {16'h0000, msb2_r[c / 8], msb3_r[c / 8]};
    pos = 6'(`QCR_UP_PER_CH * (c % 8)) + (is_k ? 6'h03 : 6'h00);
    if (is_k) begin
      return {seq[pos +: 3], mid_r[c][15:8], klo_r[c]};
    end
    return {seq[pos +: 3], mid_r[c][7:0], llo_r[c]};
  endfunction

  // Address decode: block stride is 64 words, channels inside by 7
  always_comb begin
    idx  = paddr_in[12:2];
    rel  = idx - `QCR_REG_BASE;
    blk  = rel[9:6];
    loc  = rel[5:0];
    m    = loc - LOC_SYM;
    prod = 12'(m) * `QCR_DIV7_MUL;
    n    = prod[10:8];
    r    = 3'(m - 6'(n * 3'h7));
    ch   = {blk, n};
    kind = QCR_K_NONE;
    if (paddr_in[1:0] == 2'h0 && paddr_in[15:13] == 3'h0 &&
        rel[10] == 1'b0) begin
      if (loc == LOC_MSB2) begin
        kind = QCR_K_MSB2;
      end else if (loc == LOC_MSB3) begin
        kind = QCR_K_MSB3;
      end else if (loc >= LOC_SYM) begin
        if (r == 3'h0) begin
          kind = QCR_K_SYM;
        end else if (r == R_KLO) begin
          kind = QCR_K_KLO;
        end else if (r == R_MID) begin
          kind = QCR_K_MID;
        end else if (r == R_LLO) begin
          kind = QCR_K_LLO;
        end
      end
    end
  end

  // Read mux; load bits are not stored so they read zero
  always_comb begin
    unique case (kind)
      QCR_K_MSB2: rd_data = msb2_r[blk];
      QCR_K_MSB3: rd_data = msb3_r[blk];
      QCR_K_SYM:  rd_data = {2'h0, sym_r[ch]};
      QCR_K_KLO:  rd_data = klo_r[ch];
      QCR_K_MID:  rd_data = mid_r[ch];
      QCR_K_LLO:  rd_data = llo_r[ch];
      default:    rd_data = 16'h0000;
    endcase
  end

  assign setup = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in &
                 (kind != QCR_K_NONE);

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & (kind == QCR_K_NONE);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (setup & ~pwrite_in) begin
      prdata_out <= {16'h0000, rd_data};
    end
  end

  // Register storage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int b = 0; b < `QCR_NUM_BLK; b++) begin
        msb2_r[b] <= `QCR_WORD_RST;
        msb3_r[b] <= `QCR_WORD_RST;
      end
      for (int c = 0; c < `QCR_NUM_CH; c++) begin
        sym_r[c] <= `QCR_SYM_RST;
        klo_r[c] <= `QCR_WORD_RST;
        mid_r[c] <= `QCR_WORD_RST;
        llo_r[c] <= `QCR_WORD_RST;
      end
    end else if (wr_en) begin
      unique case (kind)
        QCR_K_MSB2: msb2_r[blk] <= pwdata_in[15:0];
        QCR_K_MSB3: msb3_r[blk] <= pwdata_in[15:0];
        QCR_K_SYM:  sym_r[ch]   <= pwdata_in[13:0];
        QCR_K_KLO:  klo_r[ch]   <= pwdata_in[15:0];
        QCR_K_MID:  mid_r[ch]   <= pwdata_in[15:0];
        QCR_K_LLO:  llo_r[ch]   <= pwdata_in[15:0];
        default:    ;
      endcase
    end
  end

  // One-cycle load pulses from the self-clearing bits
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      freq_word_load_pulse_out  <= '0;
      ratio_word_load_pulse_out <= '0;
    end else begin
      for (int c = 0; c < `QCR_NUM_CH; c++) begin
        freq_word_load_pulse_out[c] <= wr_en && kind == QCR_K_SYM &&
          ch == 7'(c) && pwdata_in[`QCR_B_LDF];
        ratio_word_load_pulse_out[c] <= wr_en && kind == QCR_K_SYM &&
          ch == 7'(c) && pwdata_in[`QCR_B_LDR];
      end
    end
  end

  // Active ratio words follow staged ones only on a load
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      resampler_k_word_out <= '0;
      resampler_l_word_out <= '0;
    end else begin
      for (int c = 0; c < `QCR_NUM_CH; c++) begin
        if (ratio_word_load_pulse_out[c] ||
            (global_ratio_load_in && sym_r[c][`QCR_B_GLB])) begin
          resampler_k_word_out[c] <= ratio_word(c, 1'b1);
          resampler_l_word_out[c] <= ratio_word(c, 1'b0);
        end
      end
    end
  end

  // Symbol path configuration
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prbs_enable_out                 <= '0;
      prbs_seed_low_out               <= '0;
      rolloff_sel_out                 <= '0;
      constellation_offset_enable_out <= '0;
      constellation_sel_out           <= {`QCR_NUM_CH{`QCR_QAM_RST}};
      mapper_bypass_out               <= '1;
      half_symbol_delay_enable_out    <= '0;
      coarse_symbol_delay_out         <= '0;
    end else begin
      for (int c = 0; c < `QCR_NUM_CH; c++) begin
        prbs_enable_out[c] <= sym_r[c][`QCR_B_PRBS];
        prbs_seed_low_out[c] <= sym_r[c][`QCR_B_PRBS] ?
          sym_r[c][5:0] : 6'h00;
        rolloff_sel_out[c] <= sym_r[c][`QCR_B_ALPHA +: 2];
        constellation_offset_enable_out[c] <=
          sym_r[c][`QCR_B_CONSTELLATION_OFFSET_ENABLE];
        constellation_sel_out[c] <= sym_r[c][`QCR_B_QAM +: 3];
        mapper_bypass_out[c] <=
          sym_r[c][`QCR_B_QAM +: 3] == QCR_C_BYPASS;
        half_symbol_delay_enable_out[c] <= ~sym_r[c][`QCR_B_PRBS] &
          sym_r[c][`QCR_B_HALF];
        coarse_symbol_delay_out[c] <= sym_r[c][`QCR_B_PRBS] ?
          4'h0 : sym_r[c][`QCR_B_D1 +: 4];
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_apb_ready_timing:
    assert property (setup |=> pready_out ##1 !pready_out)
    else $error("ready not one cycle after setup");

  chk_unmapped_err:
    assert property (setup && kind == QCR_K_NONE |=> pslverr_out)
    else $error("unmapped access without error");

  chk_msb3_store:
    assert property (wr_en && kind == QCR_K_MSB3 |=>
      msb3_r[$past(blk)] == $past(pwdata_in[15:0]))
    else $error("upper ratio register not stored");

  chk_load_read_zero:
    assert property (setup && !pwrite_in && kind == QCR_K_SYM |=>
      prdata_out[15:14] == 2'h0)
    else $error("load bits read back nonzero");

  chk_freq_pulse_once:
    assert property (|freq_word_load_pulse_out |=>
      !(|freq_word_load_pulse_out))
    else $error("frequency load pulse too long");

  chk_pulse_cause:
    assert property (|ratio_word_load_pulse_out |->
      $past(wr_en && kind == QCR_K_SYM && pwdata_in[`QCR_B_LDR]))
    else $error("ratio load pulse without write");

  chk_ready_access:
    assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside an access phase");

  chk_mapped_no_err:
    assert property (setup && kind != QCR_K_NONE |=> !pslverr_out)
    else $error("error on a mapped register");

  chk_unmapped_read:
    assert property (setup && !pwrite_in && kind == QCR_K_NONE |=>
      prdata_out == 32'h00000000)
    else $error("unmapped read not zero");

  chk_sym_readback:
    assert property (setup && !pwrite_in && kind == QCR_K_SYM |=>
      prdata_out[13:0] == $past(sym_r[ch]))
    else $error("symbol register read mismatch");

  chk_msb2_store:
    assert property (wr_en && kind == QCR_K_MSB2 |=>
      msb2_r[$past(blk)] == $past(pwdata_in[15:0]))
    else $error("second upper ratio register not stored");

  chk_sym_store:
    assert property (wr_en && kind == QCR_K_SYM |=>
      sym_r[$past(ch)] == $past(pwdata_in[13:0]))
    else $error("symbol register not stored");

  chk_klo_store:
    assert property (wr_en && kind == QCR_K_KLO |=>
      klo_r[$past(ch)] == $past(pwdata_in[15:0]))
    else $error("K low word not stored");

  chk_mid_store:
    assert property (wr_en && kind == QCR_K_MID |=>
      mid_r[$past(ch)] == $past(pwdata_in[15:0]))
    else $error("middle ratio bytes not stored");

  chk_llo_store:
    assert property (wr_en && kind == QCR_K_LLO |=>
      llo_r[$past(ch)] == $past(pwdata_in[15:0]))
    else $error("L low word not stored");

  chk_freq_onehot:
    assert property ($onehot0(freq_word_load_pulse_out))
    else $error("several frequency loads at once");

  chk_ratio_pulse_once:
    assert property (|ratio_word_load_pulse_out |=>
      !(|ratio_word_load_pulse_out))
    else $error("ratio load pulse too long");

  chk_freq_cause:
    assert property (|freq_word_load_pulse_out |->
      $past(wr_en && kind == QCR_K_SYM && pwdata_in[`QCR_B_LDF]))
    else $error("frequency load pulse without write");

  for (genvar g = 0; g < `QCR_NUM_CH; g++) begin : g_chk
    chk_ratio_load:
      assert property (ratio_word_load_pulse_out[g] |=>
        resampler_k_word_out[g] == $past(ratio_word(g, 1'b1)))
      else $error("ratio word not loaded");
    chk_global_load:
      assert property (global_ratio_load_in && sym_r[g][`QCR_B_GLB] |=>
        resampler_l_word_out[g] == $past(ratio_word(g, 1'b0)))
      else $error("global ratio load missed");
    chk_prbs_seed:
      assert property (sym_r[g][`QCR_B_PRBS] |=>
        coarse_symbol_delay_out[g] == 4'h0 &&
        prbs_seed_low_out[g] == $past(sym_r[g][5:0]))
      else $error("seed bits still used as delay");
    chk_bypass_mode:
      assert property (sym_r[g][`QCR_B_QAM +: 3] == 3'h7 |=>
        mapper_bypass_out[g])
      else $error("bypass not selected");
    chk_ratio_hold:
      assert property (!ratio_word_load_pulse_out[g] &&
        !(global_ratio_load_in && sym_r[g][`QCR_B_GLB]) |=>
        $stable(resampler_k_word_out[g]) &&
        $stable(resampler_l_word_out[g]))
      else $error("ratio word changed without load");
    chk_rolloff_copy:
      assert property (1'b1 |=>
        rolloff_sel_out[g] == $past(sym_r[g][`QCR_B_ALPHA +: 2]))
      else $error("roll-off select not followed");
    chk_qam_copy:
      assert property (1'b1 |=>
        constellation_sel_out[g] == $past(sym_r[g][`QCR_B_QAM +: 3]))
      else $error("constellation select not followed");
    chk_offset_copy:
      assert property (1'b1 |=> constellation_offset_enable_out[g] ==
        $past(sym_r[g][`QCR_B_CONSTELLATION_OFFSET_ENABLE]))
      else $error("offset enable not followed");
    chk_half_delay:
      assert property (1'b1 |=> half_symbol_delay_enable_out[g] ==
        $past(sym_r[g][`QCR_B_HALF] & ~sym_r[g][`QCR_B_PRBS]))
      else $error("half-symbol delay not followed");
  end

endmodule
`default_nettype wire
